// [core/bhcp_pkg.sv]
// package: register map, field layout and reset values of the bridge control/prescaler register
// ==========================================================
// Overview of operation
// - read-only ratio field shows strap at reset release
// - speculative bit set: request after lock retry
// - speculative bit clear: request only while pending
// - write lock threshold: mode, immediate, full
// - read lock threshold: mode, immediate, below line
package bhcp_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] BHCP_CTRL_OFFSET = 12'h010;
  // ==========================================================
  // field positions inside the 32-bit word (bit 0 is the lsb)
  localparam int BHCP_RATIO_LSB = 24;
  localparam int BHCP_SPEC_BIT = 20;
  localparam int BHCP_WLT_LSB = 18;
  localparam int BHCP_RLT_LSB = 16;
  localparam int BHCP_ADJ_LSB = 0;
  // ==========================================================
  // reset values
  localparam logic BHCP_SPEC_RESET = 1'h1;
  localparam logic [1:0] BHCP_WLT_RESET = 2'h0;
  localparam logic [1:0] BHCP_RLT_RESET = 2'h0;
  localparam logic [7:0] BHCP_ADJ_RESET = 8'h9C;
  localparam logic [7:0] BHCP_ADJ_WRAP = 8'hFF;
  localparam logic [2:0] BHCP_RATIO_RESET = 3'h0;
  // ==========================================================
  // threshold selections
  typedef enum logic [1:0]
  {
    BHCP_THR_MODE = 2'b00,
    BHCP_THR_IMMEDIATE = 2'b01,
    BHCP_THR_LIMIT = 2'b10,
    BHCP_THR_LIMIT2 = 2'b11
  } bhcp_thr_e;
  // fifo status delivered by the bridge datapath
  typedef struct packed
  {
    logic writeFull;
    logic writeAtMode;
    logic readBelowLine;
    logic readAtMode;
  } bhcp_fifo_s;
endpackage

// [core/bhcp_prescaler.sv]
// module: time base prescaler counting up from the adjust value
module bhcp_prescaler
  import bhcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // adjust value and tick
  input wire logic [7:0] adjustValue,
  output logic tick
);
  logic [7:0] count_reg;

  // ==========================================================
  // counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= BHCP_ADJ_RESET;
      tick <= 1'b0;
    end
    else if (count_reg == BHCP_ADJ_WRAP)
    begin
      count_reg <= adjustValue;
      tick <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

// [core/bhcp_ctrl.sv]
// module: control-status and prescaler adjust register with APB slave
module bhcp_ctrl
  import bhcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock ratio strap
  input wire logic [2:0] ratioStrap,
  // request control
  input wire logic txnPending,
  input wire logic lockRetried,
  output logic pciRequest,
  // lock resolution
  input wire bhcp_fifo_s fifoStatus,
  input wire logic lockContend,
  output logic writeLockRetry,
  output logic readLockRetry,
  // time base
  output logic timeBaseTick
);
  logic [2:0] ratio_reg;
  logic strapDone_reg;
  logic spec_reg;
  logic [1:0] wlt_reg;
  logic [1:0] rlt_reg;
  logic [7:0] adj_reg;
  logic specArmed_reg;
  logic writeHit;
  logic readHit;
  logic access;
  logic hit;
  logic writeStrobe;
  logic [31:0] readWord;
  logic prescTick;

  assign access = psel && penable && !pready;
  assign hit = (paddr == BHCP_CTRL_OFFSET);
  // a write lands only on the edge where the master also sees pready high
  assign writeStrobe = psel && penable && pready && pwrite && hit;

  // ==========================================================
  // ratio captured by the first clocked edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ratio_reg <= BHCP_RATIO_RESET;
      strapDone_reg <= 1'b0;
    end
    else if (!strapDone_reg)
    begin
      ratio_reg <= ratioStrap;
      strapDone_reg <= 1'b1;
    end
  end

  // ==========================================================
  // writable fields; one wait state makes pready a flop
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      spec_reg <= BHCP_SPEC_RESET;
      wlt_reg <= BHCP_WLT_RESET;
      rlt_reg <= BHCP_RLT_RESET;
      adj_reg <= BHCP_ADJ_RESET;
    end
    else if (writeStrobe)
    begin
      spec_reg <= pwdata[BHCP_SPEC_BIT];
      wlt_reg <= pwdata[BHCP_WLT_LSB +: 2];
      rlt_reg <= pwdata[BHCP_RLT_LSB +: 2];
      adj_reg <= pwdata[BHCP_ADJ_LSB +: 8];
    end
  end

  always_comb
  begin
    readWord = 32'h0000_0000;
    readWord[BHCP_RATIO_LSB +: 3] = ratio_reg;
    readWord[BHCP_SPEC_BIT] = spec_reg;
    readWord[BHCP_WLT_LSB +: 2] = wlt_reg;
    readWord[BHCP_RLT_LSB +: 2] = rlt_reg;
    readWord[BHCP_ADJ_LSB +: 8] = adj_reg;
  end

  // answer flops: each stands for the single ready cycle only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= access;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= access && !hit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else
    begin
      prdata <= (access && !pwrite && hit) ? readWord : 32'h0000_0000;
    end
  end

  // ==========================================================
  // pci request; a retry arms speculation until the bus is asked again
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      specArmed_reg <= 1'b0;
    end
    else if (!spec_reg)
    begin
      specArmed_reg <= 1'b0;
    end
    else if (lockRetried)
    begin
      specArmed_reg <= 1'b1;
    end
    else if (txnPending)
    begin
      specArmed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pciRequest <= 1'b0;
    end
    else
    begin
      pciRequest <= txnPending || (spec_reg && (specArmed_reg || lockRetried));
    end
  end

  // ==========================================================
  // lock resolution thresholds
  always_comb
  begin
    case (bhcp_thr_e'(wlt_reg))
      BHCP_THR_MODE: writeHit = fifoStatus.writeAtMode;
      BHCP_THR_IMMEDIATE: writeHit = 1'b1;
      BHCP_THR_LIMIT, BHCP_THR_LIMIT2: writeHit = fifoStatus.writeFull;
      default: writeHit = fifoStatus.writeFull;
    endcase
    case (bhcp_thr_e'(rlt_reg))
      BHCP_THR_MODE: readHit = fifoStatus.readAtMode;
      BHCP_THR_IMMEDIATE: readHit = 1'b1;
      BHCP_THR_LIMIT, BHCP_THR_LIMIT2: readHit = fifoStatus.readBelowLine;
      default: readHit = fifoStatus.readBelowLine;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      writeLockRetry <= 1'b0;
    end
    else
    begin
      writeLockRetry <= lockContend && writeHit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      readLockRetry <= 1'b0;
    end
    else
    begin
      readLockRetry <= lockContend && readHit;
    end
  end

  // ==========================================================
  // time base
  bhcp_prescaler bhcp_prescaler_inst
  (
    .clk(clk),
    .rst_n(rst_n),
    .adjustValue(adj_reg),
    .tick(prescTick)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      timeBaseTick <= 1'b0;
    end
    else
    begin
      timeBaseTick <= prescTick;
    end
  end
endmodule

// [testbench/bhcp_ctrl_props.sv]
// checker: port assertions of the control-status block
module bhcp_ctrl_props
(
  // clock, reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // control
  input wire logic txnPending,
  input wire logic pciRequest,
  input wire logic lockContend,
  input wire logic writeLockRetry,
  input wire logic readLockRetry,
  input wire logic timeBaseTick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ans; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("no single ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_req; txnPending |=> pciRequest; endproperty
  a_req: assert property (p_req) else $error("request low");
  property p_wlk; writeLockRetry |-> $past(lockContend); endproperty
  a_wlk: assert property (p_wlk) else $error("write retry");
  property p_rlk; readLockRetry |-> $past(lockContend); endproperty
  a_rlk: assert property (p_rlk) else $error("read retry");
  // first wrap is about a hundred cycles away
  property p_tick; $rose(rst_n) |-> !timeBaseTick [*8]; endproperty
  a_tick: assert property (p_tick) else $error("early tick");
  c_err: cover property (pslverr);
  c_tick: cover property (timeBaseTick);
  c_lock: cover property (writeLockRetry && readLockRetry);
endmodule
bind bhcp_ctrl bhcp_ctrl_props bhcp_ctrl_props_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .txnPending(txnPending), .pciRequest(pciRequest), .lockContend(lockContend),
  .writeLockRetry(writeLockRetry), .readLockRetry(readLockRetry), .timeBaseTick(timeBaseTick));

// [testbench/bhcp_ctrl_test.sv]
// testbench: register, request, lock retry and time base checks
module bhcp_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bhcp_pkg::*;
  logic clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, er;
  logic txnPending = '0, lockRetried = '0, lockContend = '0;
  logic [11:0] paddr = '0;
  logic [2:0] ratioStrap = 3'h6;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, pciRequest, writeLockRetry, readLockRetry, timeBaseTick;
  bhcp_fifo_s fifoStatus = 4'h6;
  int errCount = 0, numChecks = 0, cyc = 0, n;
  bhcp_ctrl bhcp_ctrl_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ratioStrap(ratioStrap),
    .txnPending(txnPending), .lockRetried(lockRetried), .pciRequest(pciRequest), .fifoStatus(fifoStatus),
    .lockContend(lockContend), .writeLockRetry(writeLockRetry), .readLockRetry(readLockRetry),
    .timeBaseTick(timeBaseTick));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) tally_and_finish(1);
  task automatic tally_and_finish(input int extra);
    errCount += extra;
    $display("checks=%0d errors=%0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // entered just after an edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic pulse_retry();
    lockRetried <= 1'h1;
    @(posedge clk) lockRetried <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  // skips two ticks so the measured period was reloaded with the current adjust value
  task automatic tick_gap(output int gap);
    repeat (2)
    begin
      while (timeBaseTick !== 1'h1) @(posedge clk);
      @(posedge clk);
    end
    for (gap = 1; timeBaseTick !== 1'h1; gap++) @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    // strap moves after the capture edge and must not reach the field
    ratioStrap <= 3'h1;
    apb(1'h0, BHCP_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0610009C);
    chk(er, 1'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    // the read-only field and reserved bits 31:27 are written high to prove they are ignored
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, BHCP_CTRL_OFFSET, 32'hFF0000F0 | (i * 32'h50000));
      lockContend <= 1'h1;
      repeat (2) @(posedge clk);
      chk(writeLockRetry, i < 2);
      chk(readLockRetry, i != 0);
      // opposite fifo levels flip every threshold decision except the immediate one
      fifoStatus <= 4'h9;
      repeat (2) @(posedge clk);
      chk(writeLockRetry, i != 0);
      chk(readLockRetry, i < 2);
      fifoStatus <= 4'h6;
    end
    apb(1'h0, BHCP_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h060F00F0);
    lockContend <= 1'h0;
    repeat (2) @(posedge clk);
    chk({writeLockRetry, readLockRetry}, 2'h0);
    pulse_retry();
    chk(pciRequest, 1'h0);
    apb(1'h1, BHCP_CTRL_OFFSET, 32'h001000F0);
    pulse_retry();
    chk(pciRequest, 1'h1);
    txnPending <= 1'h1;
    @(posedge clk) txnPending <= 1'h0;
    repeat (2) @(posedge clk);
    chk(pciRequest, 1'h0);
    tick_gap(n);
    chk(n, 32'h10);
    // adjust is 256 minus the clock in MHz, so the time base ticks once a microsecond
    apb(1'h1, BHCP_CTRL_OFFSET, 32'h00100000 | (32'h100 - 32'h64));
    tick_gap(n);
    chk(n, 32'h64);
    // second reset with a new strap; the capture must follow it
    ratioStrap <= 3'h4;
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    ratioStrap <= 3'h6;
    apb(1'h0, BHCP_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0410009C);
    tally_and_finish(0);
  end
endmodule
